// ### hw/cpl_consts.svh
// register offsets, field positions, reset values and timing counts of the latch sequencer
`ifndef CPL_CONSTS_SVH
`define CPL_CONSTS_SVH

`define CPL_ADDR_SEQ_LEN      8'h00
`define CPL_ADDR_REPEAT       8'h04
`define CPL_ADDR_SEL_LOW      8'h08
`define CPL_ADDR_SEL_HIGH     8'h0C
`define CPL_ADDR_FWD_LIMIT    8'h10
`define CPL_ADDR_REV_LIMIT    8'h14
`define CPL_ADDR_COMMAND      8'h18
`define CPL_ADDR_STATUS       8'h1C
`define CPL_ADDR_IRQ_STATUS   8'h20
`define CPL_ADDR_IRQ_MASK     8'h24
`define CPL_ADDR_CAPTURED     8'h28

`define CPL_CMD_ON_BIT        0
`define CPL_CMD_OFF_BIT       1
`define CPL_CMD_MODE_LSB      4
`define CPL_MODE_CONTINUOUS   2'h1

`define CPL_STAT_CMP_BIT      10
`define CPL_STEP_LSB          8
`define CPL_RUN_BIT           16

`define CPL_EV_CAPTURE        0
`define CPL_EV_PASS           1
`define CPL_EV_DONE           2
`define CPL_EV_MODE_ERR       3

`define CPL_SEQ_LEN_MAX       4'h8
`define CPL_REPEAT_MAX        16'h00FF
`define CPL_SEL_RESET         16'h0000
`define CPL_SEL_DIGIT_MASK    16'hCCCC
`define CPL_MIN_GAP_US        500
`define CPL_CLK_MHZ           40
`define CPL_MIN_GAP_CYC       (`CPL_MIN_GAP_US * `CPL_CLK_MHZ)

`endif

// ### hw/cpl_pkg.sv
// types of the continuous position latch sequencer
package cpl_pkg;

  typedef enum logic [0:0] {
    CPL_IDLE = 1'b0,
    CPL_RUN  = 1'b1
  } cpl_state_t;

  typedef struct packed {
    cpl_state_t  st;
    logic [3:0]  seq_len;
    logic [7:0]  repeat_cnt;
    logic [15:0] sel_low;
    logic [15:0] sel_high;
    logic [31:0] fwd_limit;
    logic [31:0] rev_limit;
    logic [2:0]  step;
    logic [7:0]  pass;
    logic [3:0]  step_num;
    logic [31:0] holdoff;
    logic        cap_pend;
    logic        cmp;
    logic [31:0] captured_position;
    logic [31:0] monitor2;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  prev;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
  } cpl_regs_t;

endpackage

// ### hw/cpl_latch.sv
// continuous position latch sequencer with wishbone register slave
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cpl_consts.svh"

// Operation
// - capture position on selected triggers, steps 1..n
// - off command aborts sequence at any time
// - repeat count zero repeats without end
// - on with length zero raises warning, no start
// - complete flag bit 10 for one communications cycle
// - extended status bits 8-11 report step number
// - extended status bits 0-7 report pass count
// - pass count increments only after last step
// - monitor slot 2 forced to captured position
// - length 0..8, repeat 0..255, both reset zero
// - 4-bit digit per step selects trigger source
// - trigger within minimum gap is ignored
// - settings change only while capture stopped
// - triggers outside latch window are discarded
module cpl_latch #(
  parameter int unsigned MIN_GAP_CYC = `CPL_MIN_GAP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        comm_tick_i,
  input  wire logic [31:0] position_i,
  input  wire logic [31:0] monitor2_normal_i,
  input  wire logic        encoder_index_i,
  input  wire logic        external_trigger_one_i,
  input  wire logic        external_trigger_two_i,
  input  wire logic        external_trigger_three_i,
  output logic      [15:0] status_field_o,
  output logic      [15:0] extended_status_field_o,
  output logic      [31:0] monitor2_o,
  output logic      [31:0] captured_position_o,
  output logic             latch_complete_flag_o,
  output logic             latch_mode_error_o,
  output logic             running_o,
  output logic             irq_o
);

  cpl_pkg::cpl_regs_t r;
  cpl_pkg::cpl_regs_t next_r;

  logic        bus_req;
  logic        bus_wr;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [3:0]  edges;
  logic [15:0] sel_word;
  logic [1:0]  digit;
  logic        trig;
  logic        in_window;
  logic        capture;
  logic        last_step;
  logic        cmd_on;
  logic        cmd_off;
  logic [1:0]  cmd_mode;
  logic [3:0]  ev;
  logic [3:0]  w1c;

  always_comb begin
    next_r = r;
    ev     = 4'h0;
    w1c    = 4'h0;

    // bus decode, byte lanes merged against the stored word
    bus_req = wb_cyc_i && wb_stb_i && !r.ack;
    bus_wr  = bus_req && wb_we_i;
    wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wval    = wb_dat_i & wmask;

    // pin synchronisers, edges read only from the second stage
    next_r.sync1 = {external_trigger_three_i, external_trigger_two_i,
                    external_trigger_one_i, encoder_index_i};
    next_r.sync2 = r.sync1;
    next_r.prev  = r.sync2;
    edges        = r.sync2 & ~r.prev;

    // trigger chosen by the digit of the current step
    sel_word = r.step[2] ? r.sel_high : r.sel_low;
    digit    = sel_word[{r.step[1:0], 2'b00} +: 2];
    trig     = edges[digit];

    // allowable area: inside when fwd > rev, else outside the span
    if ($signed(r.fwd_limit) > $signed(r.rev_limit)) begin
      in_window = ($signed(position_i) <= $signed(r.fwd_limit)) &&
                  ($signed(position_i) >= $signed(r.rev_limit));
    end else begin
      in_window = ($signed(position_i) <= $signed(r.fwd_limit)) ||
                  ($signed(position_i) >= $signed(r.rev_limit));
    end

    if (r.holdoff != 32'h0000_0000) begin
      next_r.holdoff = r.holdoff - 32'h0000_0001;
    end

    capture   = (r.st == cpl_pkg::CPL_RUN) && trig && in_window &&
                (r.holdoff == 32'h0000_0000);
    last_step = ({1'b0, r.step} == (r.seq_len - 4'h1));

    cmd_on   = bus_wr && (wb_adr_i == `CPL_ADDR_COMMAND) && wval[`CPL_CMD_ON_BIT];
    cmd_off  = bus_wr && (wb_adr_i == `CPL_ADDR_COMMAND) && wval[`CPL_CMD_OFF_BIT];
    cmd_mode = wval[`CPL_CMD_MODE_LSB +: 2];

    unique case (r.st)
      cpl_pkg::CPL_IDLE: begin
        if (cmd_on && !cmd_off && cmd_mode == `CPL_MODE_CONTINUOUS) begin
          if (r.seq_len == 4'h0) begin
            ev[`CPL_EV_MODE_ERR] = 1'b1;
          end else begin
            next_r.st       = cpl_pkg::CPL_RUN;
            next_r.step     = 3'h0;
            next_r.pass     = 8'h00;
            next_r.step_num = 4'h0;
          end
        end
      end
      cpl_pkg::CPL_RUN: begin
        if (cmd_off) begin
          next_r.st = cpl_pkg::CPL_IDLE;
        end else if (capture) begin
          ev[`CPL_EV_CAPTURE] = 1'b1;
          next_r.captured_position         = position_i;
          next_r.holdoff      = 32'(MIN_GAP_CYC);
          next_r.step_num     = {1'b0, r.step} + 4'h1;
          if (last_step) begin
            next_r.step       = 3'h0;
            next_r.pass       = r.pass + 8'h01;
            ev[`CPL_EV_PASS]  = 1'b1;
            // zero repeat count never matches, so the run is endless
            if (r.repeat_cnt != 8'h00 && r.pass + 8'h01 == r.repeat_cnt) begin
              next_r.st       = cpl_pkg::CPL_IDLE;
              ev[`CPL_EV_DONE] = 1'b1;
            end
          end else begin
            next_r.step = r.step + 3'h1;
          end
        end
      end
    endcase

    // complete flag spans exactly one communications cycle
    if (comm_tick_i) begin
      next_r.cmp      = r.cap_pend || capture;
      next_r.cap_pend = 1'b0;
    end else begin
      next_r.cap_pend = r.cap_pend || capture;
    end
    next_r.monitor2 = next_r.cmp ? next_r.captured_position : monitor2_normal_i;

    // settings accepted only when stopped and in range
    if (bus_wr && r.st == cpl_pkg::CPL_IDLE) begin
      unique case (wb_adr_i)
        `CPL_ADDR_SEQ_LEN: begin
          if (wb_sel_i[0] && wval[15:0] <= {12'h000, `CPL_SEQ_LEN_MAX}) begin
            next_r.seq_len = wval[3:0];
          end
        end
        `CPL_ADDR_REPEAT: begin
          if (wb_sel_i[0] && wval[15:0] <= `CPL_REPEAT_MAX) begin
            next_r.repeat_cnt = wval[7:0];
          end
        end
        `CPL_ADDR_SEL_LOW: begin
          if (wb_sel_i[1:0] == 2'b11 && (wval[15:0] & `CPL_SEL_DIGIT_MASK) == 16'h0000) begin
            next_r.sel_low = wval[15:0];
          end
        end
        `CPL_ADDR_SEL_HIGH: begin
          if (wb_sel_i[1:0] == 2'b11 && (wval[15:0] & `CPL_SEL_DIGIT_MASK) == 16'h0000) begin
            next_r.sel_high = wval[15:0];
          end
        end
        `CPL_ADDR_FWD_LIMIT: begin
          next_r.fwd_limit = (r.fwd_limit & ~wmask) | wval;
        end
        `CPL_ADDR_REV_LIMIT: begin
          next_r.rev_limit = (r.rev_limit & ~wmask) | wval;
        end
        default: begin
        end
      endcase
    end
    if (bus_wr && wb_adr_i == `CPL_ADDR_IRQ_MASK && wb_sel_i[0]) begin
      next_r.irq_mask = wval[3:0];
    end
    if (bus_wr && wb_adr_i == `CPL_ADDR_IRQ_STATUS && wb_sel_i[0]) begin
      w1c = wval[3:0];
    end

    // sticky events, a set in the clear cycle survives
    next_r.irq_status = (r.irq_status & ~w1c) | ev;
    next_r.irq        = |(next_r.irq_status & next_r.irq_mask);

    // classic single-cycle answer; unmapped reads give zero
    next_r.ack   = bus_req;
    next_r.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `CPL_ADDR_SEQ_LEN:    next_r.rdata = {28'h000_0000, r.seq_len};
        `CPL_ADDR_REPEAT:     next_r.rdata = {24'h00_0000, r.repeat_cnt};
        `CPL_ADDR_SEL_LOW:    next_r.rdata = {16'h0000, r.sel_low};
        `CPL_ADDR_SEL_HIGH:   next_r.rdata = {16'h0000, r.sel_high};
        `CPL_ADDR_FWD_LIMIT:  next_r.rdata = r.fwd_limit;
        `CPL_ADDR_REV_LIMIT:  next_r.rdata = r.rev_limit;
        `CPL_ADDR_STATUS:     next_r.rdata = {14'h0000, r.cmp, r.st,
                                              4'h0, r.step_num, r.pass};
        `CPL_ADDR_IRQ_STATUS: next_r.rdata = {28'h000_0000, r.irq_status};
        `CPL_ADDR_IRQ_MASK:   next_r.rdata = {28'h000_0000, r.irq_mask};
        `CPL_ADDR_CAPTURED:   next_r.rdata = r.captured_position;
        default:              next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r            <= '0;
      r.st         <= cpl_pkg::CPL_IDLE;
      r.seq_len    <= 4'h0;
      r.repeat_cnt <= 8'h00;
      r.sel_low    <= `CPL_SEL_RESET;
      r.sel_high   <= `CPL_SEL_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o                = r.rdata;
  assign wb_ack_o                = r.ack;
  assign status_field_o          = {5'h00, r.cmp, 10'h000};
  assign extended_status_field_o = {4'h0, r.step_num, r.pass};
  assign monitor2_o              = r.monitor2;
  assign captured_position_o     = r.captured_position;
  assign latch_complete_flag_o   = r.cmp;
  assign latch_mode_error_o      = r.irq_status[`CPL_EV_MODE_ERR];
  assign running_o               = (r.st == cpl_pkg::CPL_RUN);
  assign irq_o                   = r.irq;

endmodule

// ### dv/cpl_latch_chk.sv
// port assertions of the latch sequencer
`timescale 1ns/1ps
module cpl_latch_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        comm_tick_i,
  input wire logic [31:0] monitor2_normal_i,
  input wire logic [15:0] status_field_o,
  input wire logic [15:0] extended_status_field_o,
  input wire logic [31:0] monitor2_o,
  input wire logic [31:0] captured_position_o,
  input wire logic        latch_complete_flag_o,
  input wire logic        latch_mode_error_o,
  input wire logic        running_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_STAT_CMP: assert property (status_field_o == {5'h00, latch_complete_flag_o, 10'h000})
    else $error("status bit mismatch");
  AST_FLAG_TICK: assert property ($changed(latch_complete_flag_o) |-> $past(comm_tick_i))
    else $error("flag moved off tick");
  AST_MON_FORCE: assert property (latch_complete_flag_o |-> monitor2_o == captured_position_o)
    else $error("monitor not forced");
  AST_MON_NORM: assert property (!latch_complete_flag_o && !$past(rst_i)
    |-> monitor2_o == $past(monitor2_normal_i))
    else $error("monitor not normal");
  AST_PASS_INC: assert property ($changed(extended_status_field_o[7:0])
    && extended_status_field_o[7:0] != 8'h00
    |-> extended_status_field_o[7:0] == $past(extended_status_field_o[7:0]) + 8'h01)
    else $error("pass count jump");
  AST_STEP_RANGE: assert property (extended_status_field_o[15:12] == 4'h0
    && extended_status_field_o[11:8] <= 4'h8)
    else $error("step number range");
  AST_IDLE_CAP: assert property (!running_o && !$past(running_o) && !$past(running_o, 2)
    |-> $stable(captured_position_o))
    else $error("capture while stopped");
  AST_ERR_NORUN: assert property ($rose(latch_mode_error_o) |-> !running_o ##1 !running_o)
    else $error("start despite mode error");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
endmodule

bind cpl_latch cpl_latch_chk u_cpl_latch_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .comm_tick_i(comm_tick_i),
  .monitor2_normal_i(monitor2_normal_i), .status_field_o(status_field_o),
  .extended_status_field_o(extended_status_field_o), .monitor2_o(monitor2_o),
  .captured_position_o(captured_position_o), .latch_complete_flag_o(latch_complete_flag_o),
  .latch_mode_error_o(latch_mode_error_o), .running_o(running_o));

// ### dv/cpl_host_link.sv
// host link model: comm cycle ticks and a changing monitor slot value
`timescale 1ns/1ps
module cpl_host_link #(
  parameter int PERIOD = 10
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  output logic             comm_tick_o,
  output logic      [31:0] monitor2_normal_o
);
  int cnt = 0;
  initial begin
    comm_tick_o = 1'b0;
    monitor2_normal_o = 32'h0000_0000;
  end
  always @(posedge clk_i) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    comm_tick_o <= (cnt == PERIOD - 1) && !rst_i;
    monitor2_normal_o <= monitor2_normal_o + 32'h0001_0001;
  end
endmodule

// ### dv/cpl_latch_test.sv
// self-checking bench of the latch sequencer
`timescale 1ns/1ps
module cpl_latch_test;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ack, tick, flag, err, run, irq;
  logic [3:0]  trg = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [15:0] stat, ext;
  logic [31:0] wdat = 32'h0000_0000, pos = 32'h0000_0000, seed = 32'h0000_c1fa;
  logic [31:0] rdat, m2n, m2, cpos, rdq[$];
  logic [47:0] e, capq[$];
  int          error_cnt = 0, checked = 0, ticks = 0;

  initial forever #12.5 clk = ~clk;
  cpl_host_link #(.PERIOD(10)) u_cpl_host_link (.clk_i(clk), .rst_i(rst), .comm_tick_o(tick),
    .monitor2_normal_o(m2n));
  cpl_latch #(.MIN_GAP_CYC(20)) u_cpl_latch (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .comm_tick_i(tick), .position_i(pos),
    .monitor2_normal_i(m2n), .encoder_index_i(trg[0]), .external_trigger_one_i(trg[1]),
    .external_trigger_two_i(trg[2]), .external_trigger_three_i(trg[3]), .status_field_o(stat),
    .extended_status_field_o(ext), .monitor2_o(m2), .captured_position_o(cpos),
    .latch_complete_flag_o(flag), .latch_mode_error_o(err), .running_o(run), .irq_o(irq));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rdq.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // zero expected status value marks a trigger that must not capture
  task automatic fire(input int s, input logic [31:0] p, input logic [15:0] x, input int gap);
    pos <= p;
    trg[s] <= 1'b1;
    if (x != 16'h0000) capq.push_back({p, x});
    repeat (4) @(posedge clk);
    trg[s] <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask

  always @(posedge clk) begin
    ticks++;
    if (ticks == 5000) begin
      error_cnt++;
      report_and_stop();
    end
    if (ack === 1'b1 && we === 1'b0) chk(rdat, rdq.pop_front());
    if ($rose(flag)) begin
      e = capq.pop_front();
      chk({cpos, ext}, e);
      chk(m2, e[47:16]);
      chk(stat, 16'h0400);
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, 8'h00, 32'h0000_0009);
    bus(1'b1, 8'h04, 32'h0000_0100);
    bus(1'b1, 8'h08, 32'h0000_0004);
    for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0000_0000);
    rd(8'h3c, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'h0000_0011);
    chk(err, 1'b1);
    chk(run, 1'b0);
    bus(1'b1, 8'h20, 32'h0000_0008);
    chk(err, 1'b0);
    bus(1'b1, 8'h00, 32'h0000_0002);
    bus(1'b1, 8'h04, 32'h0000_0002);
    bus(1'b1, 8'h08, 32'h0000_0021);
    bus(1'b1, 8'h24, 32'h0000_0001);
    bus(1'b1, 8'h18, 32'h0000_0011);
    bus(1'b1, 8'h00, 32'h0000_0005);
    rd(8'h00, 32'h0000_0002);
    for (int p = 0; p < 2; p++) begin
      seed = xs(seed);
      fire(3, seed, 16'h0000, 40);
      fire(1, ~seed, {8'h01, 8'(p)}, 8);
      fire(2, seed, 16'h0000, 40);
      fire(2, seed ^ 32'h00ff_0f00, {8'h02, 8'(p + 1)}, 40);
    end
    chk(run, 1'b0);
    chk(irq, 1'b1);
    rd(8'h1c, 32'h0000_0202);
    rd(8'h28, seed ^ 32'h00ff_0f00);
    bus(1'b1, 8'h24, 32'h0000_0000);
    chk(irq, 1'b0);
    rd(8'h20, 32'h0000_0007);
    bus(1'b1, 8'h20, 32'h0000_0007);
    bus(1'b1, 8'h24, 32'h0000_0001);
    chk(irq, 1'b0);
    bus(1'b1, 8'h10, 32'h0000_0064);
    bus(1'b1, 8'h14, 32'h0000_0032);
    bus(1'b1, 8'h00, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'h0000_0011);
    fire(0, 32'h0000_00c8, 16'h0000, 40);
    for (int k = 1; k < 4; k++) fire(0, 32'h0000_0019 * k + 32'h0000_0019, {8'h01, 8'(k)}, 40);
    bus(1'b1, 8'h18, 32'h0000_0002);
    chk(run, 1'b0);
    fire(0, 32'h0000_0050, 16'h0000, 40);
    chk(capq.size(), 0);
    report_and_stop();
  end
endmodule
